// >>> dac_serial_config_port.sv
// Serial configuration port with register file and internal reset.
// Assumes a bidirectional data pin resolved outside from sdio_oe_n, and
// serial pins asynchronous to clk, sampled here at 125 MHz.
//
// What this block does
// - Internal reset is POR, pin, soft bit ORed
// - Pin and soft reset restore defaults, port-option register kept
// - Soft reset bit high holds reset, then low
// - Bit 6 selects LSB-first for all bytes
// - Bit 7 selects 3-wire, data on data pin
// - 4-wire output driven only during read data
// - Instruction is read flag, 7-bit address, data
// - Sample on rising, shift out on falling
// - Register updates at last data bit
// - Chip select high mid-byte resets the port
`timescale 1ns/1ps
`include "dac_spi_defs.svh"
module dac_serial_config_port #(
	parameter int NUM_REGS = 32,
	parameter int ADDR_W   = 7
) (
	// Clock and power-on reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Hardware reset pin, active high
	input  wire logic hw_reset,
	// Serial pins
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic sdio_in,
	output logic      sdio_out,
	output logic      sdio_oe_n,
	output logic      serial_data_output,
	output logic      serial_data_output_oe_n,
	// Status
	output logic      internal_reset
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic       sclk_prev;
	logic       sclk_s;
	logic       cs_n_s;
	logic       sdio_s;
	logic       hw_s;
	logic       sclk_rise;
	logic       sclk_fall;

	// Two flops per pin; only the second stage feeds logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1     <= 4'h2;
			sync2     <= 4'h2;
			sclk_prev <= 1'b0;
		end else begin
			sync1     <= {hw_reset, sdio_in, cs_n, sclk};
			sync2     <= sync1;
			sclk_prev <= sync2[0];
		end
	end

	// Edge detection after the crossing
	assign sclk_s    = sync2[0];
	assign cs_n_s    = sync2[1];
	assign sdio_s    = sync2[2];
	assign hw_s      = sync2[3];
	assign sclk_rise = sclk_s & ~sclk_prev;
	assign sclk_fall = ~sclk_s & sclk_prev;

	// ****************************************
	// Register file
	// ****************************************
	dac_spi_pkg::byte_t mem      [NUM_REGS];
	dac_spi_pkg::byte_t next_mem [NUM_REGS];
	logic               int_rst;
	logic               three_wire;
	logic               lsb_first;
	logic               wr_en;
	dac_spi_pkg::byte_t wr_data;
	logic [ADDR_W-1:0]  addr;

	assign three_wire = mem[0][`OPT_3WIRE_BIT];
	assign lsb_first  = mem[0][`OPT_LSB_BIT];
	// POR is rst_n itself, which resets every flop asynchronously
	assign int_rst    = hw_s | mem[0][`OPT_SWRST_BIT];

	// Port-option register ignores internal reset so the host keeps its framing
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			always_comb begin
				next_mem[gi] = mem[gi];
				if (gi != 0 && int_rst) begin
					next_mem[gi] = `REG_RESET;
				end else if (wr_en && addr == ADDR_W'(gi)) begin
					next_mem[gi] = (gi == 0) ? (wr_data & `OPT_MASK) : wr_data;
				end
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mem[gi] <= (gi == 0) ? `OPT_RESET : `REG_RESET;
				end else begin
					mem[gi] <= next_mem[gi];
				end
			end
		end
	endgenerate

	// Reset status flop; shows POR during rst_n
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			internal_reset <= 1'b1;
		end else begin
			internal_reset <= int_rst;
		end
	end

	// ****************************************
	// Serial engine
	// ****************************************
	// Index width of the register array, so a read never indexes past its end
	localparam int IDX_W = $clog2(NUM_REGS);
	dac_spi_pkg::phase_t phase;
	dac_spi_pkg::phase_t next_phase;
	logic [2:0]          bit_idx;
	logic [2:0]          next_idx;
	dac_spi_pkg::byte_t  shift;
	dac_spi_pkg::byte_t  next_shift;
	dac_spi_pkg::byte_t  shift_in;
	dac_spi_pkg::byte_t  rdata;
	dac_spi_pkg::byte_t  next_rdata;
	logic                rw;
	logic                next_rw;
	logic [ADDR_W-1:0]   next_addr;
	logic                drive;
	logic                next_drive;
	logic                out_bit;
	logic                next_bit;

	// LSB-first fills from the top, so bit 7 is always the read flag
	assign shift_in = lsb_first ? {sdio_s, shift[7:1]} : {shift[6:0], sdio_s};

	// Next state of the engine; holds across a pause at a byte boundary
	always_comb begin
		next_phase = phase;
		next_idx   = bit_idx;
		next_shift = shift;
		next_rw    = rw;
		next_addr  = addr;
		next_rdata = rdata;
		next_drive = drive;
		next_bit   = out_bit;
		wr_en      = 1'b0;
		wr_data    = shift_in;
		if (cs_n_s) begin
			next_drive = 1'b0;
			if (bit_idx != 3'h0) begin
				next_phase = dac_spi_pkg::st_instr;
				next_idx   = 3'h0;
			end
		end else if (sclk_rise) begin
			next_shift = shift_in;
			next_idx   = bit_idx + 3'h1;
			if (bit_idx == `BIT_LAST) begin
				case (phase)
					dac_spi_pkg::st_instr: begin
						next_phase = dac_spi_pkg::st_data;
						next_rw    = shift_in[7];
						next_addr  = shift_in[ADDR_W-1:0];
						next_rdata = (32'(shift_in[ADDR_W-1:0]) < NUM_REGS) ?
							mem[shift_in[IDX_W-1:0]] : 8'h00;
					end
					dac_spi_pkg::st_data: begin
						next_phase = dac_spi_pkg::st_instr;
						wr_en      = ~rw;
						next_drive = 1'b0;
					end
					default: begin
						next_phase = dac_spi_pkg::st_instr;
					end
				endcase
			end
		end else if (sclk_fall && phase == dac_spi_pkg::st_data && rw) begin
			next_drive = 1'b1;
			next_bit   = lsb_first ? rdata[bit_idx] : rdata[`BIT_LAST - bit_idx];
		end
	end

	// Engine registers; pins are driven only while read data shifts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase                   <= dac_spi_pkg::st_instr;
			bit_idx                 <= 3'h0;
			shift                   <= 8'h00;
			rw                      <= 1'b0;
			addr                    <= '0;
			rdata                   <= 8'h00;
			drive                   <= 1'b0;
			out_bit                 <= 1'b0;
			sdio_oe_n               <= 1'b1;
			serial_data_output_oe_n <= 1'b1;
		end else begin
			phase                   <= next_phase;
			bit_idx                 <= next_idx;
			shift                   <= next_shift;
			rw                      <= next_rw;
			addr                    <= next_addr;
			rdata                   <= next_rdata;
			drive                   <= next_drive;
			out_bit                 <= next_bit;
			sdio_oe_n               <= ~(next_drive & three_wire);
			serial_data_output_oe_n <= ~(next_drive & ~three_wire);
		end
	end

	assign sdio_out           = out_bit;
	assign serial_data_output = out_bit;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_pin_reset;
		hw_s [*4] |-> ##[1:4] internal_reset;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("reset pin not seen");

	property p_opt_kept;
		(int_rst && !wr_en) |=> mem[0] == $past(mem[0]);
	endproperty
	a_opt_kept: assert property (p_opt_kept) else $error("option reg disturbed");

	property p_defaults;
		int_rst |=> mem[NUM_REGS-1] == `REG_RESET;
	endproperty
	a_defaults: assert property (p_defaults) else $error("register not defaulted");

	property p_soft_reset;
		mem[0][`OPT_SWRST_BIT] |=> internal_reset;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

	property p_three_wire_quiet;
		three_wire && $past(three_wire) |-> serial_data_output_oe_n;
	endproperty
	a_three_wire_quiet: assert property (p_three_wire_quiet) else $error("output pin on in 3-wire");

	property p_drive_only_read;
		!(sdio_oe_n && serial_data_output_oe_n) |-> rw && phase == dac_spi_pkg::st_data;
	endproperty
	a_drive_only_read: assert property (p_drive_only_read) else $error("stray drive");

	property p_out_order;
		(sclk_fall && !cs_n_s && phase == dac_spi_pkg::st_data && rw) |=>
			out_bit == ($past(lsb_first) ? $past(rdata[bit_idx]) : $past(rdata[3'h7-bit_idx]));
	endproperty
	a_out_order: assert property (p_out_order) else $error("wrong read bit");

	property p_count;
		(sclk_rise && !cs_n_s) |=> bit_idx == $past(bit_idx) + 3'h1;
	endproperty
	a_count: assert property (p_count) else $error("bit count off");

	property p_write_lands;
		(wr_en && addr == ADDR_W'(3) && !int_rst) |=> mem[3] == $past(wr_data);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write lost");

	property p_abort;
		(cs_n_s && bit_idx != 3'h0) |=> bit_idx == 3'h0 && phase == dac_spi_pkg::st_instr;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort mid-byte");

	c_write: cover property (wr_en);
	c_read3: cover property (!sdio_oe_n);
	c_read4: cover property (!serial_data_output_oe_n);
	c_soft: cover property (mem[0][`OPT_SWRST_BIT] ##[1:200] !mem[0][`OPT_SWRST_BIT]);
endmodule : dac_serial_config_port

// >>> dac_spi_defs.svh
// Offsets, field positions, reset values and timing counts of the serial config port.
// Assumes inclusion by bare name from the port module.
`ifndef DAC_SPI_DEFS_SVH
`define DAC_SPI_DEFS_SVH
// ****************************************
// Register map
// ****************************************
`define OPT_ADDR       7'h00
`define OPT_3WIRE_BIT  7
`define OPT_LSB_BIT    6
`define OPT_SWRST_BIT  5
`define OPT_MASK       8'hE0
`define OPT_RESET      8'h00
`define REG_RESET      8'h00
`define BIT_LAST       3'h7
// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS  8
`define HW_RST_MIN_NS  40
`define HW_RST_MIN_CYC ((`HW_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_MAX_MHZ   20
`endif

// >>> dac_spi_pkg.sv
// Types shared by the serial config port.
// Assumes the defs header is on the include path.
package dac_spi_pkg;
	// Transfer phase: instruction byte, then data byte
	typedef enum logic {st_instr, st_data} phase_t;
	typedef logic [7:0] byte_t;
endpackage : dac_spi_pkg

// >>> spi_host_model.sv
// Host master model that runs transfers on the serial config port.
// Assumes the bench resolves the data pin from sdio_oe_n; sclk idles low.
`timescale 1ns/1ps
module spi_host_model (
	// Clock
	input  wire logic clk,
	// Serial pins
	output logic      sclk,
	output logic      cs_n,
	output logic      host_sdio,
	input  wire logic sdio_line,
	input  wire logic sdio_oe_n,
	input  wire logic serial_data_output,
	input  wire logic serial_data_output_oe_n
);
	// ****************
	// Transfers
	// ****************
	// Idle: deselected, clock standing low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_sdio = 1'b0;
	end
	// Ten clk a half period: 6.25 MHz link
	task automatic half;
		repeat (10) @(posedge clk);
	endtask : half
	// One frame; nb below 16 and not a multiple of 8 aborts mid-byte, pz stalls at the byte edge
	task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
		input logic lsb, input logic tw, input logic pz, input int nb,
		output logic [7:0] rdat);
		logic [15:0] f;
		int n;
		f = {rd, addr, wd};
		rdat = 8'h00;
		cs_n <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			n = lsb ? (i < 8 ? 8 + i : i - 8) : 15 - i;
			if (pz && i == 8) begin
				sclk <= 1'b0;
				half;
				cs_n <= 1'b1;
				half;
				cs_n <= 1'b0;
			end
			sclk <= 1'b0;
			// Released pin shows the inverse, never a stale copy
			host_sdio <= (rd && i >= 8) ? ~host_sdio : f[n];
			half;
			// Only the pin of the chosen mode may be enabled
			if (rd && i >= 8)
				rdat[n[2:0]] = tw ? ((sdio_oe_n === 1'b0 && serial_data_output_oe_n === 1'b1)
					? sdio_line : 1'bz)
					: ((serial_data_output_oe_n === 1'b0 && sdio_oe_n === 1'b1)
					? serial_data_output : 1'bz);
			sclk <= 1'b1;
			half;
		end
		sclk <= 1'b0;
		cs_n <= 1'b1;
		half;
	endtask : xfer
endmodule : spi_host_model

// >>> dac_serial_config_port_tb.sv
// Self-checking bench for the serial config port, driving it through the host model.
// Assumes NUM_REGS of 32, so address 0x40 is unmapped.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module dac_serial_config_port_tb;
	logic clk;
	logic rst_n;
	logic hw_reset;
	logic lsb;
	logic tw;
	wire  sclk;
	wire  cs_n;
	wire  host_sdio;
	wire  sdio_line;
	wire  sdio_out;
	wire  sdio_oe_n;
	wire  serial_data_output;
	wire  serial_data_output_oe_n;
	wire  internal_reset;
	int   mismatches = 0;
	int   n_checks = 0;
	// Data pin: device wins while its enable is low
	assign sdio_line = sdio_oe_n ? host_sdio : sdio_out;
	dac_serial_config_port dut (.clk(clk), .rst_n(rst_n), .hw_reset(hw_reset), .sclk(sclk),
		.cs_n(cs_n), .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.serial_data_output(serial_data_output),
		.serial_data_output_oe_n(serial_data_output_oe_n), .internal_reset(internal_reset));
	spi_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .host_sdio(host_sdio),
		.sdio_line(sdio_line), .sdio_oe_n(sdio_oe_n), .serial_data_output(serial_data_output),
		.serial_data_output_oe_n(serial_data_output_oe_n));
	// ****************
	// Tasks
	// ****************
	task automatic finish_test;
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic pz = 1'b0,
		input int nb = 16);
		logic [7:0] r;
		host.xfer(1'b0, a, d, lsb, tw, pz, nb, r);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		host.xfer(1'b1, a, 8'h00, lsb, tw, 1'b0, 16, r);
		`CHK(r, e)
	endtask : rd
	// Pin pulse of five clk, the 40 ns minimum
	task automatic pin_reset;
		hw_reset <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK(internal_reset, 1'b1)
		hw_reset <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(internal_reset, 1'b0)
	endtask : pin_reset
	// ****************
	// Sequence
	// ****************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Long stall counts as a failure
	initial begin
		#300000;
		mismatches++;
		finish_test;
	end
	initial begin
		rst_n = 1'b0;
		hw_reset = 1'b0;
		lsb = 1'b0;
		tw = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		pin_reset;
		rd(7'h00, 8'h00);
		wr(7'h03, 8'h5A);
		rd(7'h03, 8'h5A);
		wr(7'h04, 8'hC3, 1'b1);
		rd(7'h04, 8'hC3);
		wr(7'h04, 8'hFF, 1'b0, 12);
		rd(7'h04, 8'hC3);
		wr(7'h00, 8'h40);
		lsb = 1'b1;
		pin_reset;
		rd(7'h03, 8'h00);
		rd(7'h00, 8'h40);
		wr(7'h05, 8'h96);
		rd(7'h05, 8'h96);
		wr(7'h00, 8'hC0);
		tw = 1'b1;
		rd(7'h05, 8'h96);
		wr(7'h00, 8'hE7);
		repeat (6) @(posedge clk);
		`CHK(internal_reset, 1'b1)
		rd(7'h00, 8'hE0);
		rd(7'h05, 8'h00);
		wr(7'h00, 8'hC0);
		repeat (6) @(posedge clk);
		`CHK(internal_reset, 1'b0)
		wr(7'h05, 8'h11);
		rd(7'h05, 8'h11);
		wr(7'h00, 8'h00);
		lsb = 1'b0;
		tw = 1'b0;
		rd(7'h40, 8'h00);
		rd(7'h05, 8'h11);
		finish_test;
	end
endmodule : dac_serial_config_port_tb
